// file: logic/pll_lock_gear_clock_control.sv
/*
  Clock controller: PLL lock and hard reset sequencing, limp mode,
  gear divider, timebase and periodic clocks, APB register file.
  Assumes presetn is the power-on reset, all clock pins are slow next to
  pclk, and the PLL output itself is modelled as one tick per pclk.
*/
// The register offsets and the APB slave port were decided locally.
module pll_lock_gear_clock_control
  import clk_ctrl_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_lock_in,
  input wire logic crystal_clock_in,
  input wire logic external_clock_in,
  input wire logic ring_backup_clock,
  input wire logic clock_mode_pin1,
  input wire logic clock_mode_pin2,
  input wire logic clock_mode_pin3,
  output logic hard_reset_n,
  output logic pll_output_enable,
  output logic limp_active,
  output logic [11:0] pll_multiplier,
  output logic system_timer_tick,
  output logic timebase_clock,
  output logic periodic_timer_clock,
  output logic core_phase1_clock,
  output logic core_phase2_clock,
  output logic bus_phase1_clock,
  output logic bus_phase2_clock,
  output logic lock_irq
);
  logic [6:0] pins;
  logic locked, xtal_s, ext_s, bu_s;
  logic locked_d, xtal_d, ext_d, bu_d;
  logic xtal_tick, ext_tick, bu_tick, ref_tick, lock_edge, sys_tick;
  logic [2:0] mode_latched, next_mode;
  logic [2:0] cap_cnt, next_cap_cnt;
  logic captured, next_captured, capture;
  logic [14:0] defaults;
  logic [2:0] fast_gear_divider, next_fast;
  logic [2:0] slow_gear_divider, next_slow;
  logic [1:0] bus_clock_divider, next_bus_clock_divider;
  logic timebase_source_select, next_tbs;
  logic periodic_clock_divide, next_periodic_clock_divide;
  logic periodic_clock_source, next_periodic_clock_source;
  logic limp_enable, next_lme;
  logic backup_switch_request, next_bsr;
  logic gear_select, next_gear;
  logic lock_loss_reset_enable, next_lock_loss_reset_enable;
  logic [11:0] next_mf;
  logic lock_change_flag, next_chg;
  logic lock_timeout, next_tmo;
  logic lock_irq_enable, next_irqen;
  logic [31:0] next_prdata;
  logic mapped, wr_en, rd_setup;
  hr_state_t hr_state, next_hr_state;
  logic [9:0] hr_cnt, next_hr_cnt;
  logic [9:0] wait_cnt, next_wait_cnt;
  logic [9:0] lock_limit;
  logic [3:0] div_exp;
  logic src_tick, tb_src, pit_src;
  logic [3:0] tb_cnt, next_tb_cnt, tb_last;
  logic [7:0] pit_cnt, next_pit_cnt, pit_last;
  logic next_tb_clk, next_pit_clk;

  sync3 #(.W(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({pll_lock_in, crystal_clock_in, external_clock_in,
          ring_backup_clock, clock_mode_pin1, clock_mode_pin2,
          clock_mode_pin3}),
    .dout(pins)
  );

  assign locked = pins[6];
  assign xtal_s = pins[5];
  assign ext_s = pins[4];
  assign bu_s = pins[3];
  assign xtal_tick = xtal_s && !xtal_d;
  assign ext_tick = ext_s && !ext_d;
  assign bu_tick = bu_s && !bu_d;
  assign lock_edge = locked ^ locked_d;
  assign ref_tick = mode_latched[2] ? ext_tick : xtal_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_d <= 1'b0;
      xtal_d <= 1'b0;
      ext_d <= 1'b0;
      bu_d <= 1'b0;
      system_timer_tick <= 1'b0;
    end else begin
      locked_d <= locked;
      xtal_d <= xtal_s;
      ext_d <= ext_s;
      bu_d <= bu_s;
      system_timer_tick <= ref_tick;
    end
  end

  // mode pins taken once the synchroniser has settled after release
  assign capture = !captured && (cap_cnt == CAP_LAST);
  assign defaults = mode_defaults(pins[2:0]);

  always_comb begin
    next_cap_cnt = cap_cnt;
    next_captured = captured;
    next_mode = mode_latched;
    if (!captured) begin
      next_cap_cnt = 3'(cap_cnt + 3'h1);
    end
    if (capture) begin
      next_captured = 1'b1;
      next_mode = pins[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_cnt <= 3'h0;
      captured <= 1'b0;
      mode_latched <= 3'h0;
    end else begin
      cap_cnt <= next_cap_cnt;
      captured <= next_captured;
      mode_latched <= next_mode;
    end
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign mapped = ((paddr >> 4) == '0) && (paddr[1:0] == 2'h0);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      next_prdata = 32'h0;
      if (mapped) begin
        case (paddr[3:0])
          CCR_OFS: begin
            next_prdata[FAST_LSB+:3] = fast_gear_divider;
            next_prdata[SLOW_LSB+:3] = slow_gear_divider;
            next_prdata[BUS_CLOCK_DIVIDER_LSB+:2] = bus_clock_divider;
            next_prdata[TBS_BIT] = timebase_source_select;
            next_prdata[PERIODIC_CLOCK_DIVIDE_BIT] = periodic_clock_divide;
            next_prdata[PERIODIC_CLOCK_SOURCE_BIT] = periodic_clock_source;
            next_prdata[LME_BIT] = limp_enable;
            next_prdata[BSR_BIT] = backup_switch_request;
            next_prdata[GEAR_BIT] = gear_select;
          end
          PCR_OFS: begin
            next_prdata[MF_LSB+:12] = pll_multiplier;
            next_prdata[LOCK_LOSS_RESET_ENABLE_BIT] = lock_loss_reset_enable;
          end
          STS_OFS: begin
            next_prdata[LOCK_BIT] = locked;
            next_prdata[LIMP_BIT] = limp_active;
            next_prdata[CHG_BIT] = lock_change_flag;
            next_prdata[TMO_BIT] = lock_timeout;
            next_prdata[MODE_LSB+:3] = mode_latched;
          end
          MSK_OFS: next_prdata[IRQEN_BIT] = lock_irq_enable;
          default: next_prdata = 32'h0;
        endcase
      end
    end
  end

  always_comb begin
    next_fast = fast_gear_divider;
    next_slow = slow_gear_divider;
    next_bus_clock_divider = bus_clock_divider;
    next_tbs = timebase_source_select;
    next_periodic_clock_divide = periodic_clock_divide;
    next_periodic_clock_source = periodic_clock_source;
    next_lme = limp_enable;
    next_bsr = backup_switch_request;
    next_gear = gear_select;
    next_lock_loss_reset_enable = lock_loss_reset_enable;
    next_mf = pll_multiplier;
    next_chg = lock_change_flag;
    next_irqen = lock_irq_enable;
    if (wr_en && paddr[3:0] == CCR_OFS) begin
      next_fast = pwdata[FAST_LSB+:3];
      next_slow = pwdata[SLOW_LSB+:3];
      next_bus_clock_divider = pwdata[BUS_CLOCK_DIVIDER_LSB+:2];
      next_tbs = pwdata[TBS_BIT];
      next_periodic_clock_divide = pwdata[PERIODIC_CLOCK_DIVIDE_BIT];
      next_periodic_clock_source = pwdata[PERIODIC_CLOCK_SOURCE_BIT];
      next_lme = pwdata[LME_BIT];
      next_bsr = pwdata[BSR_BIT];
      next_gear = pwdata[GEAR_BIT];
    end
    if (wr_en && paddr[3:0] == PCR_OFS) begin
      next_mf = pwdata[MF_LSB+:12];
      next_lock_loss_reset_enable = pwdata[LOCK_LOSS_RESET_ENABLE_BIT];
    end
    if (wr_en && paddr[3:0] == MSK_OFS) begin
      next_irqen = pwdata[IRQEN_BIT];
    end
    if (wr_en && paddr[3:0] == STS_OFS && pwdata[CHG_BIT]) begin
      next_chg = 1'b0;
    end
    if (lock_edge) begin
      next_chg = 1'b1;
    end
    if (capture) begin
      next_lme = defaults[14];
      next_periodic_clock_source = defaults[13];
      next_periodic_clock_divide = defaults[12];
      next_mf = defaults[11:0];
    end
    if (hr_state != HR_RUN) begin
      next_bsr = !locked;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      fast_gear_divider <= DIV_RST;
      slow_gear_divider <= DIV_RST;
      bus_clock_divider <= BUS_CLOCK_DIVIDER_RST;
      timebase_source_select <= 1'b0;
      periodic_clock_divide <= 1'b0;
      periodic_clock_source <= 1'b0;
      limp_enable <= 1'b0;
      backup_switch_request <= 1'b0;
      gear_select <= 1'b0;
      lock_loss_reset_enable <= 1'b0;
      pll_multiplier <= 12'h000;
      lock_change_flag <= 1'b0;
      lock_irq_enable <= 1'b0;
    end else begin
      prdata <= next_prdata;
      fast_gear_divider <= next_fast;
      slow_gear_divider <= next_slow;
      bus_clock_divider <= next_bus_clock_divider;
      timebase_source_select <= next_tbs;
      periodic_clock_divide <= next_periodic_clock_divide;
      periodic_clock_source <= next_periodic_clock_source;
      limp_enable <= next_lme;
      backup_switch_request <= next_bsr;
      gear_select <= next_gear;
      lock_loss_reset_enable <= next_lock_loss_reset_enable;
      pll_multiplier <= next_mf;
      lock_change_flag <= next_chg;
      lock_irq_enable <= next_irqen;
    end
  end

  assign lock_irq = lock_change_flag && lock_irq_enable;
  assign limp_active = backup_switch_request && limp_enable;
  assign pll_output_enable = (hr_state != HR_WAIT);
  assign lock_limit = (pll_multiplier <= LOCK_MF_SPLIT) ?
                      LOCK_SHORT : LOCK_LONG;

  // hard reset sequencing
  always_comb begin
    next_hr_state = hr_state;
    next_hr_cnt = hr_cnt;
    next_wait_cnt = wait_cnt;
    next_tmo = lock_timeout;
    case (hr_state)
      HR_WAIT: begin
        if (locked && captured) begin
          next_hr_state = HR_COUNT;
          next_hr_cnt = 10'h0;
        end else if (ref_tick && wait_cnt != lock_limit) begin
          next_wait_cnt = 10'(wait_cnt + 10'h1);
        end
        if (wait_cnt == lock_limit) begin
          next_tmo = 1'b1;
        end
      end
      HR_COUNT: begin
        if (!locked) begin
          next_hr_state = HR_WAIT;
        end else if (sys_tick) begin
          if (hr_cnt == HR_RELEASE_CYCLES - 10'h1) begin
            next_hr_state = HR_RUN;
          end else begin
            next_hr_cnt = 10'(hr_cnt + 10'h1);
          end
        end
      end
      HR_RUN: begin
        // loss with reset enable clear keeps the PLL running the chip
        if (!locked && locked_d && lock_loss_reset_enable) begin
          next_hr_state = HR_WAIT;
          next_wait_cnt = 10'h0;
        end
      end
      default: next_hr_state = HR_WAIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hr_state <= HR_WAIT;
      hr_cnt <= 10'h0;
      wait_cnt <= 10'h0;
      lock_timeout <= 1'b0;
      hard_reset_n <= 1'b0;
    end else begin
      hr_state <= next_hr_state;
      hr_cnt <= next_hr_cnt;
      wait_cnt <= next_wait_cnt;
      lock_timeout <= next_tmo;
      hard_reset_n <= (next_hr_state == HR_RUN);
    end
  end

  // divider source and ratio
  assign src_tick = limp_active ? bu_tick : pll_output_enable;
  assign div_exp = gear_select ? 4'({1'b0, slow_gear_divider} + 4'h1) :
                   {1'b0, fast_gear_divider};

  gear_divider u_gear (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .div_exp(div_exp),
    .bus_div(bus_clock_divider),
    .core_phase1_clock(core_phase1_clock),
    .core_phase2_clock(core_phase2_clock),
    .bus_phase1_clock(bus_phase1_clock),
    .bus_phase2_clock(bus_phase2_clock),
    .sys_tick(sys_tick)
  );

  // timebase and periodic clocks
  always_comb begin
    tb_src = limp_active ? bu_tick :
             (timebase_source_select ? sys_tick : ref_tick);
    tb_last = (timebase_source_select || pll_multiplier <= 12'h001) ?
              TB_DIV_LARGE : TB_DIV_SMALL - 4'h1;
    pit_src = limp_active ? bu_tick :
              (periodic_clock_source ? ext_tick : xtal_tick);
    pit_last = periodic_clock_divide ? PIT_DIV_LARGE : PIT_DIV_SMALL;
    next_tb_cnt = tb_cnt;
    next_pit_cnt = pit_cnt;
    next_tb_clk = 1'b0;
    next_pit_clk = 1'b0;
    if (tb_src) begin
      next_tb_clk = (tb_cnt >= tb_last);
      next_tb_cnt = next_tb_clk ? 4'h0 : 4'(tb_cnt + 4'h1);
    end
    if (pit_src) begin
      next_pit_clk = (pit_cnt >= pit_last);
      next_pit_cnt = next_pit_clk ? 8'h0 : 8'(pit_cnt + 8'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_cnt <= 4'h0;
      pit_cnt <= 8'h0;
      timebase_clock <= 1'b0;
      periodic_timer_clock <= 1'b0;
    end else begin
      tb_cnt <= next_tb_cnt;
      pit_cnt <= next_pit_cnt;
      timebase_clock <= next_tb_clk;
      periodic_timer_clock <= next_pit_clk;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pll_held_off: assert property (
    !locked_d && !locked |=> !pll_output_enable || $past(hr_state) != HR_WAIT)
    else $error("pll output enabled before lock");
  a_no_limp_noenable: assert property (
    !limp_enable |-> !limp_active && (src_tick == pll_output_enable))
    else $error("backup clock used without limp enable");
  a_lol_keeps_pll: assert property (
    hr_state == HR_RUN && !lock_loss_reset_enable |=> hard_reset_n)
    else $error("lock loss caused reset with reset enable clear");
  a_lol_resets: assert property (
    hr_state == HR_RUN && lock_loss_reset_enable && locked_d && !locked
    |=> !hard_reset_n && !pll_output_enable)
    else $error("lock loss with reset enable did not disable pll");
  a_bsr_in_reset: assert property (
    hr_state != HR_RUN |=> backup_switch_request == !$past(locked))
    else $error("backup request not following lock in hard reset");
  a_hr_release: assert property (
    hr_state == HR_COUNT && locked && sys_tick &&
    hr_cnt == HR_RELEASE_CYCLES - 10'h1 |=> hard_reset_n)
    else $error("hard reset not released after release count");
  a_mode_frozen: assert property (
    captured |=> $stable(mode_latched))
    else $error("mode pins resampled after capture");
  a_irq_on_change: assert property (
    lock_edge && lock_irq_enable |=> lock_irq [*2])
    else $error("lock change did not raise interrupt");
  a_sysclk_ref: assert property (
    ref_tick |=> system_timer_tick)
    else $error("timer tick lost reference edge");

  c_release: cover property ($rose(hard_reset_n));
  c_limp: cover property ($rose(limp_active));
  c_lock_loss: cover property (hr_state == HR_RUN && $fell(locked));
  c_gear: cover property (gear_select && bus_phase2_clock);
endmodule : pll_lock_gear_clock_control

// file: logic/clk_ctrl_pkg.sv
/*
  Constants for the clock controller: register offsets, field positions,
  reset values, divide ratios, lock timing and the reset mode table.
  Assumes a 32-bit APB slave with byte addresses 0x0..0xc.
*/
package clk_ctrl_pkg;
  // register byte offsets
  localparam logic [3:0] CCR_OFS = 4'h0;
  localparam logic [3:0] PCR_OFS = 4'h4;
  localparam logic [3:0] STS_OFS = 4'h8;
  localparam logic [3:0] MSK_OFS = 4'hc;
  // clock_control_reg fields
  localparam int FAST_LSB = 0;
  localparam int SLOW_LSB = 4;
  localparam int BUS_CLOCK_DIVIDER_LSB = 8;
  localparam int TBS_BIT = 12;
  localparam int PERIODIC_CLOCK_DIVIDE_BIT = 13;
  localparam int PERIODIC_CLOCK_SOURCE_BIT = 14;
  localparam int LME_BIT = 16;
  localparam int BSR_BIT = 17;
  localparam int GEAR_BIT = 18;
  // pll_control_reg fields
  localparam int MF_LSB = 0;
  localparam int LOCK_LOSS_RESET_ENABLE_BIT = 16;
  // status and mask fields
  localparam int LOCK_BIT = 0;
  localparam int LIMP_BIT = 1;
  localparam int CHG_BIT = 2;
  localparam int TMO_BIT = 3;
  localparam int MODE_LSB = 4;
  localparam int IRQEN_BIT = 0;
  // reset values
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [1:0] BUS_CLOCK_DIVIDER_RST = 2'h0;
  // timing
  localparam logic [2:0] CAP_LAST = 3'h4;
  localparam logic [9:0] HR_RELEASE_CYCLES = 10'h200;
  localparam logic [9:0] LOCK_SHORT = 10'h1f4;
  localparam logic [9:0] LOCK_LONG = 10'h3e8;
  localparam logic [11:0] LOCK_MF_SPLIT = 12'h004;
  localparam logic [3:0] TB_DIV_SMALL = 4'h4;
  localparam logic [3:0] TB_DIV_LARGE = 4'hf;
  localparam logic [7:0] PIT_DIV_SMALL = 8'h03;
  localparam logic [7:0] PIT_DIV_LARGE = 8'hff;
  localparam logic [11:0] MF_X5 = 12'h004;
  localparam logic [11:0] MF_X1 = 12'h000;

  typedef enum logic [1:0] {HR_WAIT, HR_COUNT, HR_RUN} hr_state_t;

  // reset defaults {lme, periodic_clock_source, periodic_clock_divide, mf} per mode pins {pin1,pin2,pin3}
  function automatic logic [14:0] mode_defaults(input logic [2:0] mode);
    case (mode)
      3'h0: mode_defaults = {3'h0, MF_X1};
      3'h1: mode_defaults = {3'h1, MF_X1};
      3'h2: mode_defaults = {3'h5, MF_X5};
      3'h3: mode_defaults = {3'h5, MF_X1};
      3'h6: mode_defaults = {3'h3, MF_X5};
      3'h7: mode_defaults = {3'h7, MF_X1};
      default: mode_defaults = {3'h3, MF_X1};
    endcase
  endfunction : mode_defaults
endpackage : clk_ctrl_pkg

// file: logic/sync3.sv
/*
  Three-stage pin synchroniser; output follows once stages two and three
  agree. Assumes inputs are asynchronous to pclk.
*/
module sync3 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1, s2, s3;
  logic [W-1:0] next_dout;

  always_comb begin
    next_dout = dout;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_dout[i] = s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : sync3

// file: logic/gear_divider.sv
/*
  Low-power divider: turns source ticks into core and bus clock phases.
  Assumes src_tick is a one-cycle enable standing for one oscillator edge.
*/
module gear_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire logic [3:0] div_exp,
  input wire logic [1:0] bus_div,
  output logic core_phase1_clock,
  output logic core_phase2_clock,
  output logic bus_phase1_clock,
  output logic bus_phase2_clock,
  output logic sys_tick
);
  logic [9:0] cnt, next_cnt, last, half;
  logic [1:0] bcnt, next_bcnt;
  logic next_p1, next_p2, next_b1, next_b2, next_tick;

  always_comb begin
    // period is at least two source ticks
    last = 10'((11'h2 << div_exp) - 11'h1);
    half = 10'(11'h1 << div_exp);
    next_cnt = cnt;
    next_bcnt = bcnt;
    next_p1 = core_phase1_clock;
    next_p2 = core_phase2_clock;
    next_b1 = bus_phase1_clock;
    next_b2 = bus_phase2_clock;
    next_tick = 1'b0;
    if (src_tick) begin
      // ratio applies at once; a count past the new end wraps
      next_cnt = (cnt >= last) ? 10'h0 : 10'(cnt + 10'h1);
      if (next_cnt == 10'h0) begin
        next_bcnt = (bcnt >= bus_div) ? 2'h0 : 2'(bcnt + 2'h1);
      end
      next_p1 = (next_cnt == 10'h0);
      next_p2 = (next_cnt == half);
      next_tick = next_p2;
      next_b1 = next_p1 && (next_bcnt == 2'h0);
      next_b2 = next_p2 && (next_bcnt == 2'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 10'h0;
      bcnt <= 2'h0;
      core_phase1_clock <= 1'b0;
      core_phase2_clock <= 1'b0;
      bus_phase1_clock <= 1'b0;
      bus_phase2_clock <= 1'b0;
      sys_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      bcnt <= next_bcnt;
      core_phase1_clock <= next_p1;
      core_phase2_clock <= next_p2;
      bus_phase1_clock <= next_b1;
      bus_phase2_clock <= next_b2;
      sys_tick <= next_tick;
    end
  end
endmodule : gear_divider

// file: testbench/ref_source.sv
/*
  Far-side model: crystal, external and ring clocks plus a PLL lock flag.
  Assumes lock_want comes from the bench; lock follows 8 crystal edges.
*/
module ref_source (
  input wire logic lock_want,
  output logic crystal_clock_in,
  output logic external_clock_in,
  output logic ring_backup_clock,
  output logic pll_lock_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial begin
    crystal_clock_in = 1'b0;
    external_clock_in = 1'b0;
    ring_backup_clock = 1'b0;
  end
  // all clocks slow next to pclk
  always #40 crystal_clock_in = ~crystal_clock_in;
  always #60 external_clock_in = ~external_clock_in;
  always #30 ring_backup_clock = ~ring_backup_clock;
  always @(posedge crystal_clock_in) begin
    if (!lock_want) n <= 0;
    else if (n < 8) n <= n + 1;
  end
  assign pll_lock_in = (n == 8);
endmodule : ref_source

// file: testbench/pll_lock_gear_clock_control_test.sv
/*
  Self-checking bench for the clock controller over APB.
  Assumes the reference model drives clocks and lock; mode pins 010, then
  011 across a mid-run reset.
*/
module pll_lock_gear_clock_control_test
  import clk_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [3:0] paddr = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, lock_want = 0, lk, xc, ec, rc;
  logic hrn, poe, limp, stt, tbc, ptc, c1, c2, b1, b2, irq, se;
  logic [11:0] mf;
  int err_total = 0, check_count = 0, cyc = 0, n;
  int k1, k2, kb1, kb2, kst, ktb, kpt, kx;
  logic [2:0] mode = 3'h2;
  ref_source PART (.lock_want(lock_want), .crystal_clock_in(xc),
    .external_clock_in(ec), .ring_backup_clock(rc), .pll_lock_in(lk));
  pll_lock_gear_clock_control DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_lock_in(lk), .crystal_clock_in(xc), .external_clock_in(ec),
    .ring_backup_clock(rc), .clock_mode_pin1(mode[2]),
    .clock_mode_pin2(mode[1]), .clock_mode_pin3(mode[0]),
    .hard_reset_n(hrn), .pll_output_enable(poe), .limp_active(limp),
    .pll_multiplier(mf), .system_timer_tick(stt), .timebase_clock(tbc),
    .periodic_timer_clock(ptc), .core_phase1_clock(c1),
    .core_phase2_clock(c2), .bus_phase1_clock(b1),
    .bus_phase2_clock(b2), .lock_irq(irq));
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chkb
  task automatic apb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the registers written at the access edge settle
    @(posedge pclk);
  endtask : apb
  task automatic wait_run();
    for (n = 0; n < 4000 && hrn !== 1'b1; n++) @(posedge pclk);
  endtask : wait_run
  // counts clock phase and tick pulses over 64 cycles
  task automatic sample64();
    k1 = 0;
    k2 = 0;
    kb1 = 0;
    kb2 = 0;
    kst = 0;
    ktb = 0;
    kpt = 0;
    kx = 0;
    repeat (64) begin
      @(posedge pclk);
      k1 += int'(c1);
      k2 += int'(c2);
      kb1 += int'(b1);
      kb2 += int'(b2);
      kst += int'(stt);
      ktb += int'(tbc);
      kpt += int'(ptc);
      if ((b1 && !c1) || (b2 && !c2)) kx++;
    end
  endtask : sample64
  task automatic t_reset();
    chkb(poe, 1'b0);
    chk({20'h0, mf}, 32'h4);
    apb(1'b0, STS_OFS, 32'h0);
    chk({29'h0, r[6:4]}, 32'h2);
    apb(1'b0, PCR_OFS, 32'h0);
    chk({20'h0, r[11:0]}, 32'h4);
    apb(1'b0, CCR_OFS, 32'h0);
    chk({25'h0, r[6:0]}, 32'h0);
    chk({28'h0, r[16:13]}, 32'h9);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_lock();
    lock_want <= 1'b1;
    for (n = 0; n < 200 && lk !== 1'b1; n++) @(posedge pclk);
    repeat (500) @(posedge pclk);
    chkb(hrn, 1'b0);
    wait_run();
    chkb(hrn, 1'b1);
    chkb(poe, 1'b1);
    chkb(limp, 1'b0);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_limp();
    apb(1'b1, CCR_OFS, 32'h0003_0000);
    chkb(limp, 1'b1);
    apb(1'b1, CCR_OFS, 32'h0002_0000);
    chkb(limp, 1'b0);
    apb(1'b1, CCR_OFS, 32'h0);
    $display("t_limp done");
  endtask : t_limp
  task automatic t_gear();
    // fast divide 4, bus at half the core rate
    apb(1'b1, CCR_OFS, 32'h0000_0101);
    repeat (8) @(posedge pclk);
    sample64();
    chk(k1, 32'd16);
    chk(k2, 32'd16);
    chk(kb1, 32'd8);
    chk(kb2, 32'd8);
    chk(kx, 32'd0);
    chk(kst, 32'd8);
    chk(ktb, 32'd2);
    chk(kpt, 32'd2);
    // slow gear with a zero field divides by four
    apb(1'b1, CCR_OFS, 32'h0004_0000);
    repeat (8) @(posedge pclk);
    sample64();
    chk(k2, 32'd16);
    chk(kb2, 32'd16);
    apb(1'b1, CCR_OFS, 32'h0);
    repeat (8) @(posedge pclk);
    sample64();
    chk(k2, 32'd32);
    $display("t_gear done");
  endtask : t_gear
  task automatic t_lol();
    apb(1'b1, MSK_OFS, 32'h1);
    apb(1'b1, STS_OFS, 32'h4);
    apb(1'b1, PCR_OFS, 32'h4);
    lock_want <= 1'b0;
    repeat (40) @(posedge pclk);
    chkb(hrn, 1'b1);
    chkb(irq, 1'b1);
    apb(1'b1, MSK_OFS, 32'h0);
    chkb(irq, 1'b0);
    lock_want <= 1'b1;
    for (n = 0; n < 200 && lk !== 1'b1; n++) @(posedge pclk);
    repeat (10) @(posedge pclk);
    apb(1'b1, PCR_OFS, 32'h0001_0004);
    lock_want <= 1'b0;
    repeat (40) @(posedge pclk);
    chkb(hrn, 1'b0);
    chkb(poe, 1'b0);
    apb(1'b0, CCR_OFS, 32'h0);
    chkb(r[17], 1'b1);
    lock_want <= 1'b1;
    wait_run();
    chkb(hrn, 1'b1);
    $display("t_lol done");
  endtask : t_lol
  task automatic t_mode();
    @(posedge pclk);
    presetn <= 1'b0;
    mode <= 3'h3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    mode <= 3'h0;
    repeat (10) @(posedge pclk);
    apb(1'b0, STS_OFS, 32'h0);
    chk({29'h0, r[6:4]}, 32'h3);
    apb(1'b0, PCR_OFS, 32'h0);
    chk({20'h0, r[11:0]}, 32'h0);
    apb(1'b0, CCR_OFS, 32'h0);
    chk({28'h0, r[16:13]}, 32'h9);
    $display("t_mode done");
  endtask : t_mode
  task automatic t_bad();
    apb(1'b0, 4'h2, 32'h0);
    chkb(se, 1'b1);
    chk(r, 32'h0);
    $display("t_bad done");
  endtask : t_bad
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    t_reset();
    t_lock();
    t_limp();
    t_gear();
    t_lol();
    t_mode();
    t_bad();
    tally_and_finish();
  end
endmodule : pll_lock_gear_clock_control_test
